// [src/gpio_port_pkg.sv]
// Purpose: shared constants and types for the two-port pin configuration block
// Assumes: 8-bit cpu data bus with an 8-bit data-space address
// Notes:   offsets are data-space byte addresses

package gpio_port_pkg;

  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] PORT_A_PIN_DATA_OFS   = 8'hc0;
  localparam logic [7:0] PORT_B_PIN_DATA_OFS   = 8'hc1;
  localparam logic [7:0] PORT_A_DIRECTION_OFS  = 8'hc4;
  localparam logic [7:0] PORT_B_DIRECTION_OFS  = 8'hc5;
  localparam logic [7:0] PORT_A_PIN_OPTION_OFS = 8'hcc;
  localparam logic [7:0] PORT_B_PIN_OPTION_OFS = 8'hcd;
  localparam logic [7:0] PORT_REG_RESET        = 8'h00;

  // ---------------------------------------------------------------------------
  // trigger modes and sizes
  // ---------------------------------------------------------------------------
  localparam int         PORT_WIDTH       = 8;
  localparam logic [1:0] TRIG_FALLING     = 2'h0;
  localparam logic [1:0] TRIG_RISING      = 2'h1;
  localparam logic [1:0] TRIG_LOW_LEVEL   = 2'h2;
  localparam logic [7:0] PIN_SYNC_RESET   = 8'hff; // pulled-up idle level

  typedef enum logic [1:0] {
    PIN_STATIC,
    PIN_EDGE_SEEN
  } edge_state_t;

  // one port's configuration registers
  typedef struct packed {
    logic [7:0] direction_bits;
    logic [7:0] pin_option;
    logic [7:0] pin_level_latch;
  } port_cfg_t;

  // per-pin drive and sense controls of one port
  typedef struct packed {
    logic [7:0] out_value;
    logic [7:0] out_enable;
    logic [7:0] pull_up_en;
    logic [7:0] analog_sel;
    logic [7:0] irq_sel;
  } pin_ctrl_t;

endpackage

// [src/gpio_port_lane.sv]
// Purpose: one 8-bit port: pin decode, pin synchroniser, interrupt request
// Assumes: configuration registers kept by the parent
// Notes:   all outputs are registered

`timescale 1ns/1ps
`default_nettype none

module gpio_port_lane (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire gpio_port_pkg::port_cfg_t cfg,
  input  wire logic [7:0]              pin_in,
  input  wire logic                    global_irq_enable,
  input  wire logic [1:0]              trig_mode,
  output var  logic [7:0]              pin_level_r,
  output var  gpio_port_pkg::pin_ctrl_t ctrl_r,
  output var  logic                    irq_req_r
);

  // ---------------------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------------------
  logic [7:0] sync1_r;
  logic [7:0] sync1_nxt;
  logic [7:0] sync2_nxt;

  // first stage feeds only the second stage
  always_comb begin
    sync1_nxt = pin_in;
    sync2_nxt = sync1_r;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r     <= gpio_port_pkg::PIN_SYNC_RESET;
      pin_level_r <= gpio_port_pkg::PIN_SYNC_RESET;
    end else begin
      sync1_r     <= sync1_nxt;
      pin_level_r <= sync2_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // per-pin decode of direction, option and data bits
  // ---------------------------------------------------------------------------
  gpio_port_pkg::pin_ctrl_t ctrl_nxt;
  logic [7:0]               prev_r;
  logic [7:0]               hit;
  logic                     irq_nxt;

  genvar n;
  generate
    for (n = 0; n < gpio_port_pkg::PORT_WIDTH; n++) begin : g_pin
      logic dir;
      logic opt;
      logic dat;
      assign dir = cfg.direction_bits[n];
      assign opt = cfg.pin_option[n];
      assign dat = cfg.pin_level_latch[n];
      // open drain shares the push-pull stage with the high side held off
      assign ctrl_nxt.out_value[n]  = dir & dat;
      assign ctrl_nxt.out_enable[n] = dir & (opt | ~dat);
      assign ctrl_nxt.pull_up_en[n] = ~dir & ~dat;
      assign ctrl_nxt.analog_sel[n] = ~dir & opt & dat;
      assign ctrl_nxt.irq_sel[n]    = ~dir & opt & ~dat;
      // trigger per port: falling, rising or low level
      always_comb begin
        case (trig_mode)
          gpio_port_pkg::TRIG_RISING:
            hit[n] = ~prev_r[n] & pin_level_r[n];
          gpio_port_pkg::TRIG_LOW_LEVEL:
            hit[n] = ~pin_level_r[n];
          default:
            hit[n] = prev_r[n] & ~pin_level_r[n];
        endcase
      end
    end
  endgenerate

  // all enabled pins of the port merge onto one request line
  always_comb begin
    irq_nxt = global_irq_enable & |(hit & ctrl_r.irq_sel);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r    <= '0;
      prev_r    <= gpio_port_pkg::PIN_SYNC_RESET;
      irq_req_r <= 1'b0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      prev_r    <= pin_level_r;
      irq_req_r <= irq_nxt;
    end
  end

endmodule

`default_nettype wire

// [src/gpio_ports.sv]
// Purpose: two 8-bit general purpose ports in cpu data space
// Assumes: cpu strobes are synchronous to SYS_CLK, one cycle wide
// Notes:   trigger mode and interrupt enable arrive from the interrupt block
//
// Overview of operation
// - reset clears every port register: inputs with pull-up, no interrupt
// - bit n of each register steers only pin n of its port
// - direction 0 makes an input, 1 an output; all bits writable
// - input: option,data 00 pull-up, 01 plain, 10 pull-up irq, 11 analog
// - output: option 0 open drain, option 1 push-pull; data sets the level
// - data read of an input pin returns the live pin level
// - output pin: writes update the latch, reads return the latch
// - latch 0 drives low; 1 drives high push-pull, floats open drain
// - open drain is push-pull with the high driver switched off
// - pin interrupts only in pull-up irq input with global enable set
// - trigger is falling, rising or low level, chosen per port
// - analog-configured pins are routed to the converter multiplexer
// - peripherals never take a pin without matching register settings
// - wait and stop leave ports untouched; enabled pin events wake
// - no wait or stop entry while an enabled request is pending
// - port a requests its own vector; port b the next lower one

`timescale 1ns/1ps
`default_nettype none

module gpio_ports (
  input  wire logic       SYS_CLK,
  input  wire logic       RST_N,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR_EN,
  input  wire logic       RD_EN,
  output logic      [7:0] RDATA,
  output logic            RDATA_VALID,
  input  wire logic       GLOBAL_IRQ_ENABLE,
  input  wire logic [1:0] TRIG_MODE_A,
  input  wire logic [1:0] TRIG_MODE_B,
  input  wire logic       LOW_POWER_REQ,
  output logic            LOW_POWER_GRANT,
  output logic            WAKE,
  output logic            IRQ_PORT_A,
  output logic            IRQ_PORT_B,
  input  wire logic [7:0] PA_IN,
  output logic      [7:0] PA_OUT,
  output logic      [7:0] PA_OE,
  output logic      [7:0] PA_PULL_UP,
  output logic      [7:0] PA_ANALOG_SEL,
  input  wire logic [7:0] PB_IN,
  output logic      [7:0] PB_OUT,
  output logic      [7:0] PB_OE,
  output logic      [7:0] PB_PULL_UP,
  output logic      [7:0] PB_ANALOG_SEL
);

  // ---------------------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------------------
  gpio_port_pkg::port_cfg_t cfg_a_r;
  gpio_port_pkg::port_cfg_t cfg_a_nxt;
  gpio_port_pkg::port_cfg_t cfg_b_r;
  gpio_port_pkg::port_cfg_t cfg_b_nxt;

  // plain byte writes; no side effects beyond storing the value
  always_comb begin
    cfg_a_nxt = cfg_a_r;
    cfg_b_nxt = cfg_b_r;
    if (WR_EN) begin
      case (ADDR)
        gpio_port_pkg::PORT_A_PIN_DATA_OFS:
          cfg_a_nxt.pin_level_latch = WDATA;
        gpio_port_pkg::PORT_B_PIN_DATA_OFS:
          cfg_b_nxt.pin_level_latch = WDATA;
        gpio_port_pkg::PORT_A_DIRECTION_OFS:
          cfg_a_nxt.direction_bits = WDATA;
        gpio_port_pkg::PORT_B_DIRECTION_OFS:
          cfg_b_nxt.direction_bits = WDATA;
        gpio_port_pkg::PORT_A_PIN_OPTION_OFS:
          cfg_a_nxt.pin_option = WDATA;
        gpio_port_pkg::PORT_B_PIN_OPTION_OFS:
          cfg_b_nxt.pin_option = WDATA;
        default: ;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_a_r <= {3{gpio_port_pkg::PORT_REG_RESET}};
      cfg_b_r <= {3{gpio_port_pkg::PORT_REG_RESET}};
    end else begin
      cfg_a_r <= cfg_a_nxt;
      cfg_b_r <= cfg_b_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // the two ports
  // ---------------------------------------------------------------------------
  logic [7:0]               lvl_a;
  logic [7:0]               lvl_b;
  gpio_port_pkg::pin_ctrl_t ctl_a;
  gpio_port_pkg::pin_ctrl_t ctl_b;
  logic                     req_a;
  logic                     req_b;

  gpio_port_lane u_port_a (
    .sys_clk           (SYS_CLK),
    .rst_n             (RST_N),
    .cfg               (cfg_a_r),
    .pin_in            (PA_IN),
    .global_irq_enable (GLOBAL_IRQ_ENABLE),
    .trig_mode         (TRIG_MODE_A),
    .pin_level_r       (lvl_a),
    .ctrl_r            (ctl_a),
    .irq_req_r         (req_a)
  );

  gpio_port_lane u_port_b (
    .sys_clk           (SYS_CLK),
    .rst_n             (RST_N),
    .cfg               (cfg_b_r),
    .pin_in            (PB_IN),
    .global_irq_enable (GLOBAL_IRQ_ENABLE),
    .trig_mode         (TRIG_MODE_B),
    .pin_level_r       (lvl_b),
    .ctrl_r            (ctl_b),
    .irq_req_r         (req_b)
  );

  // pin controls leave the lanes registered; direct to the pins
  // alternate functions get no path here, pins follow registers only
  always_comb begin
    PA_OUT        = ctl_a.out_value;
    PA_OE         = ctl_a.out_enable;
    PA_PULL_UP    = ctl_a.pull_up_en;
    PA_ANALOG_SEL = ctl_a.analog_sel;
    PB_OUT        = ctl_b.out_value;
    PB_OE         = ctl_b.out_enable;
    PB_PULL_UP    = ctl_b.pull_up_en;
    PB_ANALOG_SEL = ctl_b.analog_sel;
    IRQ_PORT_A    = req_a;
    IRQ_PORT_B    = req_b;
  end

  // ---------------------------------------------------------------------------
  // register read path
  // ---------------------------------------------------------------------------
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       rvalid_r;
  logic       rvalid_nxt;

  // data reads mix live pin level for inputs with the latch for outputs
  always_comb begin
    rvalid_nxt = RD_EN;
    rdata_nxt  = 8'h00;
    if (RD_EN) begin
      case (ADDR)
        gpio_port_pkg::PORT_A_PIN_DATA_OFS:
          rdata_nxt = (lvl_a & ~cfg_a_r.direction_bits) |
                      (cfg_a_r.pin_level_latch & cfg_a_r.direction_bits);
        gpio_port_pkg::PORT_B_PIN_DATA_OFS:
          rdata_nxt = (lvl_b & ~cfg_b_r.direction_bits) |
                      (cfg_b_r.pin_level_latch & cfg_b_r.direction_bits);
        gpio_port_pkg::PORT_A_DIRECTION_OFS:
          rdata_nxt = cfg_a_r.direction_bits;
        gpio_port_pkg::PORT_B_DIRECTION_OFS:
          rdata_nxt = cfg_b_r.direction_bits;
        gpio_port_pkg::PORT_A_PIN_OPTION_OFS:
          rdata_nxt = cfg_a_r.pin_option;
        gpio_port_pkg::PORT_B_PIN_OPTION_OFS:
          rdata_nxt = cfg_b_r.pin_option;
        default:
          rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  always_comb begin
    RDATA       = rdata_r;
    RDATA_VALID = rvalid_r;
  end

  // ---------------------------------------------------------------------------
  // low-power handshake and wake
  // ---------------------------------------------------------------------------
  logic grant_r;
  logic grant_nxt;
  logic wake_r;
  logic wake_nxt;
  logic pending;

  // port state is never touched here, so wait and stop change nothing
  always_comb begin
    pending   = req_a | req_b;
    grant_nxt = LOW_POWER_REQ & ~pending;
    wake_nxt  = pending;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      grant_r <= 1'b0;
      wake_r  <= 1'b0;
    end else begin
      grant_r <= grant_nxt;
      wake_r  <= wake_nxt;
    end
  end

  always_comb begin
    LOW_POWER_GRANT = grant_r;
    WAKE            = wake_r;
  end

endmodule

`default_nettype wire

// [dv/gpio_ports_assertions.sv]
// Purpose: port-level checks for the two-port pin block
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to every gpio_ports instance
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_checker (
  input wire logic       SYS_CLK,
  input wire logic       RST_N,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR_EN,
  input wire logic       RD_EN,
  input wire logic [7:0] RDATA,
  input wire logic       RDATA_VALID,
  input wire logic       GLOBAL_IRQ_ENABLE,
  input wire logic       LOW_POWER_REQ,
  input wire logic       LOW_POWER_GRANT,
  input wire logic       WAKE,
  input wire logic       IRQ_PORT_A,
  input wire logic       IRQ_PORT_B,
  input wire logic [7:0] PA_OE,
  input wire logic [7:0] PA_PULL_UP,
  input wire logic [7:0] PB_OE,
  input wire logic [7:0] PB_PULL_UP,
  input wire logic [7:0] PB_ANALOG_SEL
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  property p_rd_answer;
    RD_EN |=> RDATA_VALID;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read unanswered");
  property p_rd_quiet;
    !RD_EN |=> !RDATA_VALID && RDATA == 8'h00;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("stray read data");
  // a port a direction write bounds its drivers two cycles on
  property p_dir_oe;
    WR_EN && ADDR == gpio_port_pkg::PORT_A_DIRECTION_OFS
      |-> ##2 (PA_OE & ~$past(WDATA, 2)) == 8'h00;
  endproperty
  a_dir_oe: assert property (p_dir_oe) else $error("input pin driven");
  property p_pull_out;
    (PA_PULL_UP & PA_OE) == 8'h00;
  endproperty
  a_pull_out: assert property (p_pull_out) else $error("pull-up on output");
  property p_analog_in;
    (PB_ANALOG_SEL & (PB_OE | PB_PULL_UP)) == 8'h00;
  endproperty
  a_analog_in: assert property (p_analog_in) else $error("analog pin busy");
  property p_gen_off;
    !GLOBAL_IRQ_ENABLE [*3] |=> !IRQ_PORT_A && !IRQ_PORT_B;
  endproperty
  a_gen_off: assert property (p_gen_off) else $error("irq while disabled");
  property p_wake;
    IRQ_PORT_A || IRQ_PORT_B |=> WAKE;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on request");
  property p_no_grant;
    IRQ_PORT_A || IRQ_PORT_B |=> !LOW_POWER_GRANT;
  endproperty
  a_no_grant: assert property (p_no_grant) else $error("sleep while pending");
  property p_grant_cause;
    LOW_POWER_GRANT |-> $past(LOW_POWER_REQ);
  endproperty
  a_grant_cause: assert property (p_grant_cause) else $error("unasked grant");
  c_read: cover property (RDATA_VALID);
  c_irq: cover property (IRQ_PORT_A);
  c_grant: cover property (LOW_POWER_GRANT);
endmodule
bind gpio_ports gpio_ports_checker u_gpio_ports_checker (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
  .WR_EN(WR_EN), .RD_EN(RD_EN), .RDATA(RDATA), .RDATA_VALID(RDATA_VALID),
  .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .LOW_POWER_REQ(LOW_POWER_REQ),
  .LOW_POWER_GRANT(LOW_POWER_GRANT), .WAKE(WAKE), .IRQ_PORT_A(IRQ_PORT_A),
  .IRQ_PORT_B(IRQ_PORT_B), .PA_OE(PA_OE), .PA_PULL_UP(PA_PULL_UP),
  .PB_OE(PB_OE), .PB_PULL_UP(PB_PULL_UP), .PB_ANALOG_SEL(PB_ANALOG_SEL));
`default_nettype wire

// [dv/pin_board_model.sv]
// Purpose: board circuitry on one 8-pin port
// Assumes: chip driver wins over the board source
// Notes:   undriven, unpulled pins wander every cycle
`timescale 1ns/1ps
`default_nettype none
module pin_board_model (
  input  wire logic       clk,
  input  wire logic [7:0] drive_val,
  input  wire logic [7:0] drive_en,
  input  wire logic [7:0] pull_up,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  output var  logic [7:0] pin
);
  // ----------------------------------------
  // pin resolution
  // ----------------------------------------
  logic [7:0] float_r = 8'h55;
  // a floating pin never holds a stale level
  always_ff @(posedge clk) float_r <= ~float_r;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (drive_en[i]) pin[i] = drive_val[i];
      else if (ext_en[i]) pin[i] = ext_val[i];
      else if (pull_up[i]) pin[i] = 1'b1;
      else pin[i] = float_r[i];
    end
  end
endmodule
`default_nettype wire

// [dv/gpio_ports_test.sv]
// Purpose: register-sequence bench for the two-port pin block
// Assumes: one access per strobe, answers one cycle later
// Notes:   port b pins have no board source; pull-ups hold them, except pin 0 once analog
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_test;
  // ----------------------------------------
  // stimulus and wiring
  // ----------------------------------------
  logic       sys_clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
  logic       gen = 1'b0, lp_req = 1'b0, rvalid, grant, wake, irq_a, irq_b;
  logic [1:0] trig = 2'h0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, ext_val = 8'h00, ext_en = 8'h00;
  logic [7:0] rdata, pa_in, pa_out, pa_oe, pa_pu, pa_an;
  logic [7:0] pb_in, pb_out, pb_oe, pb_pu, pb_an;
  int         fails = 0, samples_checked = 0;
  always #5 sys_clk = ~sys_clk;
  gpio_ports u_gpio_ports (.SYS_CLK(sys_clk), .RST_N(rst_n), .ADDR(addr),
    .WDATA(wdata), .WR_EN(wr_en), .RD_EN(rd_en), .RDATA(rdata),
    .RDATA_VALID(rvalid), .GLOBAL_IRQ_ENABLE(gen), .TRIG_MODE_A(trig),
    .TRIG_MODE_B(trig), .LOW_POWER_REQ(lp_req), .LOW_POWER_GRANT(grant),
    .WAKE(wake), .IRQ_PORT_A(irq_a), .IRQ_PORT_B(irq_b), .PA_IN(pa_in),
    .PA_OUT(pa_out), .PA_OE(pa_oe), .PA_PULL_UP(pa_pu),
    .PA_ANALOG_SEL(pa_an), .PB_IN(pb_in), .PB_OUT(pb_out), .PB_OE(pb_oe),
    .PB_PULL_UP(pb_pu), .PB_ANALOG_SEL(pb_an));
  pin_board_model u_pin_board_model_a (.clk(sys_clk), .drive_val(pa_out),
    .drive_en(pa_oe), .pull_up(pa_pu), .ext_val(ext_val), .ext_en(ext_en),
    .pin(pa_in));
  pin_board_model u_pin_board_model_b (.clk(sys_clk), .drive_val(pb_out),
    .drive_en(pb_oe), .pull_up(pb_pu), .ext_val(8'h00), .ext_en(8'h00),
    .pin(pb_in));
  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge sys_clk);
    wr_en <= 1'b1; addr <= a; wdata <= d;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(posedge sys_clk);
    rd_en <= 1'b1; addr <= a;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    @(negedge sys_clk);
    chk("rdata_valid", {7'h00, rvalid}, 8'h01);
    chk("rdata", rdata, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // bounded poll; a missed request counts against the run
  task automatic wait_irq(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (8) begin
      @(negedge sys_clk);
      if (irq_a === 1'b1) seen = 1'b1;
    end
    chk("irq_port_a", {7'h00, seen}, {7'h00, exp});
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    cyc(5);
    rst_n <= 1'b1;
    cyc(3);
    #1;
    chk("pa_oe", pa_oe, 8'h00);
    chk("pa_pull_up", pa_pu, 8'hff);
    rd(gpio_port_pkg::PORT_A_DIRECTION_OFS, 8'h00);
    rd(gpio_port_pkg::PORT_B_PIN_OPTION_OFS, 8'h00);
    rd(gpio_port_pkg::PORT_B_PIN_DATA_OFS, 8'hff);
    rd(8'hc2, 8'h00);
    // mixed port: od and pp outputs over live inputs
    @(posedge sys_clk);
    ext_en <= 8'h0f; ext_val <= 8'h06;
    wr(gpio_port_pkg::PORT_A_DIRECTION_OFS, 8'hf0);
    wr(gpio_port_pkg::PORT_A_PIN_OPTION_OFS, 8'hc0);
    wr(gpio_port_pkg::PORT_A_PIN_DATA_OFS, 8'ha5);
    cyc(4);
    #1;
    chk("pa_oe", pa_oe, 8'hd0);
    chk("pa_out", pa_out & pa_oe, 8'h80);
    chk("pa_pull_up", pa_pu, 8'h0a);
    chk("pa_analog", pa_an, 8'h00);
    chk("pb_oe", pb_oe, 8'h00);
    chk("pb_out", pb_out, 8'h00);
    rd(gpio_port_pkg::PORT_A_PIN_DATA_OFS, 8'ha6);
    rd(gpio_port_pkg::PORT_A_PIN_OPTION_OFS, 8'hc0);
    // plain input first, then analog: never through the irq state
    wr(gpio_port_pkg::PORT_B_PIN_DATA_OFS, 8'h01);
    wr(gpio_port_pkg::PORT_B_PIN_OPTION_OFS, 8'h01);
    cyc(3);
    #1;
    chk("pb_analog", pb_an, 8'h01);
    chk("pb_pull_up", pb_pu, 8'hfe);
    // pin 0 of port a as pull-up interrupt input
    // data cleared before option set, so pin 0 never passes analog
    wr(gpio_port_pkg::PORT_A_DIRECTION_OFS, 8'h00);
    wr(gpio_port_pkg::PORT_A_PIN_DATA_OFS, 8'h00);
    wr(gpio_port_pkg::PORT_A_PIN_OPTION_OFS, 8'h01);
    @(posedge sys_clk);
    ext_en <= 8'h01; ext_val <= 8'h01; gen <= 1'b1;
    trig <= gpio_port_pkg::TRIG_FALLING;
    cyc(6);
    ext_val <= 8'h00;
    wait_irq(1'b1);
    @(posedge sys_clk);
    trig <= gpio_port_pkg::TRIG_RISING;
    cyc(6);
    ext_val <= 8'h01;
    wait_irq(1'b1);
    chk("irq_port_b", {7'h00, irq_b}, 8'h00);
    @(posedge sys_clk);
    gen <= 1'b0; trig <= gpio_port_pkg::TRIG_FALLING;
    cyc(6);
    ext_val <= 8'h00;
    wait_irq(1'b0);
    @(posedge sys_clk);
    ext_val <= 8'h01; gen <= 1'b1;
    wr(gpio_port_pkg::PORT_A_PIN_OPTION_OFS, 8'h00);
    cyc(6);
    ext_val <= 8'h00;
    wait_irq(1'b0);
    // level trigger holds the request and blocks sleep
    @(posedge sys_clk);
    ext_val <= 8'h01;
    wr(gpio_port_pkg::PORT_A_PIN_OPTION_OFS, 8'h01);
    @(posedge sys_clk);
    trig <= gpio_port_pkg::TRIG_LOW_LEVEL; lp_req <= 1'b1;
    cyc(6);
    #1;
    chk("grant", {7'h00, grant}, 8'h01);
    @(posedge sys_clk);
    ext_val <= 8'h00;
    wait_irq(1'b1);
    chk("grant", {7'h00, grant}, 8'h00);
    chk("wake", {7'h00, wake}, 8'h01);
    results();
  end
endmodule
`default_nettype wire
